// >>> adc_consts.svh
// Constants for the identification and status register block
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// Register indices; byte address is four times the index
`define ADC_IDX_ID 6'h00
`define ADC_IDX_STATUS 6'h01
`define ADC_IDX_IRQ_STATUS 6'h02
`define ADC_IDX_IRQ_MASK 6'h03

// Identification fields
`define ADC_ID_CODE_MSB 15
`define ADC_ID_CODE_LSB 12
`define ADC_ID_COUNT_MSB 11
`define ADC_ID_COUNT_LSB 8
`define ADC_CHANNEL_COUNT 4'h6

// Status reset values
`define ADC_STATUS_RESET 16'h0500
`define ADC_WLEN_RESET 2'h1
`define ADC_CRC_TYPE_RESET 1'h0
`define ADC_LOCK_RESET 1'h0
`define ADC_RESET_FLAG_RESET 1'h1

// Interrupt status and mask layout
`define ADC_IRQ_WIDTH 9
`define ADC_IRQ_RESYNC 0
`define ADC_IRQ_REGMAP 1
`define ADC_IRQ_CRCERR 2
`define ADC_IRQ_DATA_LSB 3
`define ADC_IRQ_MASK_RESET 9'h000

`endif

// >>> adc_pkg.sv
// Types shared by the identification and status register block
package adc_pkg;

    // Status word as it is read by the host
    typedef struct packed {
        logic locked;
        logic resyncOccurred;
        logic regMapChanged;
        logic inputCrcError;
        logic crcTypeAnsi;
        logic resetOccurred;
        logic [1:0] wordLengthCode;
        logic [1:0] reserved;
        logic [5:0] newData;
    } adc_status_type;

    // Events and levels coming from the converter core
    typedef struct packed {
        logic ifaceLocked;
        logic resyncPulse;
        logic regMapCrcChangedPulse;
        logic inputCrcErrPulse;
        logic crcTypeAnsi;
        logic [1:0] wordLengthSel;
        logic [5:0] newDataPulse;
        logic [5:0] dataTakenPulse;
        logic resetFlagClear;
    } adc_core_events_type;

    // Bus handshake phase
    typedef enum logic [0:0] {
        ADC_BUS_IDLE = 1'b0,
        ADC_BUS_ACK = 1'b1
    } adc_bus_state_type;

    // Register index from a byte address
    function automatic logic [5:0] adc_reg_index(input logic [7:0] byteAddr);
        return byteAddr[7:2];
    endfunction

endpackage

// >>> adc_flag_bank.sv
// Bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module adc_flag_bank #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] setFlag,
    input wire logic [WIDTH-1:0] clearFlag,
    output logic [WIDTH-1:0] flagsD,
    output logic [WIDTH-1:0] flagsQ
);

    ////////////////////////////////////////////////////////////////
    // Next value: set wins over clear
    always_comb begin
        flagsD = setFlag | (flagsQ & ~clearFlag);
    end

    // Flag storage
    always_ff @(posedge clk) begin
        if (reset) begin
            flagsQ <= RESET_VALUE;
        end else begin
            flagsQ <= flagsD;
        end
    end

endmodule

`default_nettype wire

// >>> adc_id_status_regs.sv
// Identification and status registers with an Avalon-MM slave and interrupt
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"

module adc_id_status_regs
    import adc_pkg::*;
#(
    // Arbitrary device code and revision byte, not tied to any part
    parameter logic [3:0] DEVICE_CODE = 4'h5,
    parameter logic [7:0] REVISION_BYTE = 8'h00
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire adc_core_events_type coreEvents,
    output adc_status_type statusOut,
    output logic irq
);

    ////////////////////////////////////////////////////////////////
    // Declarations
    adc_bus_state_type busState_q;
    adc_bus_state_type busState_d;
    logic waitrequest_q;
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    logic irq_q;
    logic locked_q;
    logic crcTypeAnsi_q;
    logic [1:0] wordLengthCode_q;
    logic [`ADC_IRQ_WIDTH-1:0] irqMask_q;
    // Decode and lane helpers
    logic request;
    logic readCapture;
    logic accept;
    logic [5:0] regIndex;
    logic statusReadAccept;
    logic irqStatusWriteAccept;
    logic irqMaskWriteAccept;
    logic [15:0] idWord;
    logic [15:0] writeLow;
    logic [15:0] laneMask;
    // Flag banks
    logic [2:0] eventSet;
    logic [2:0] eventClear;
    logic [2:0] eventFlags_q;
    logic [5:0] dataFlags_q;
    logic [0:0] resetFlag_q;
    // Interrupt and status words
    logic [`ADC_IRQ_WIDTH-1:0] irqSet;
    logic [`ADC_IRQ_WIDTH-1:0] irqClear;
    logic [`ADC_IRQ_WIDTH-1:0] irqStatus_d;
    logic [`ADC_IRQ_WIDTH-1:0] irqStatus_q;
    adc_status_type status_d;
    adc_status_type status_q;

    ////////////////////////////////////////////////////////////////
    // True when the decoded index names the given register
    function automatic logic index_is(input logic [5:0] have, input logic [5:0] want);
        return have == want;
    endfunction

    // Keep bits of disabled lanes, take bits of enabled lanes
    function automatic logic [`ADC_IRQ_WIDTH-1:0] lane_merge(
        input logic [`ADC_IRQ_WIDTH-1:0] oldBits,
        input logic [`ADC_IRQ_WIDTH-1:0] newBits,
        input logic [`ADC_IRQ_WIDTH-1:0] lanes
    );
        return (oldBits & ~lanes) | (newBits & lanes);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Bus decode
    assign request = read | write;
    assign accept = request & ~waitrequest_q;
    assign regIndex = adc_reg_index(address);
    assign statusReadAccept = accept & read & index_is(regIndex, `ADC_IDX_STATUS);
    assign irqStatusWriteAccept = accept & write & index_is(regIndex, `ADC_IDX_IRQ_STATUS);
    assign irqMaskWriteAccept = accept & write & index_is(regIndex, `ADC_IDX_IRQ_MASK);

    // Read data are taken in the wait cycle of a request
    assign readCapture = request & waitrequest_q;

    // Byte lanes 0 and 1 carry the 16-bit registers
    assign laneMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    assign writeLow = writedata[15:0] & laneMask;

    // Handshake phase: one wait cycle, then acknowledge
    always_comb begin
        busState_d = busState_q;
        unique case (busState_q)
            ADC_BUS_IDLE: begin
                if (request) begin
                    busState_d = ADC_BUS_ACK;
                end
            end
            ADC_BUS_ACK: begin
                busState_d = ADC_BUS_IDLE;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge clk) begin
        if (reset) begin
            busState_q <= ADC_BUS_IDLE;
        end else begin
            busState_q <= busState_d;
        end
    end

    // Waitrequest low only in the acknowledge cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            waitrequest_q <= 1'b1;
        end else begin
            waitrequest_q <= (busState_d != ADC_BUS_ACK);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Identification word
    always_comb begin
        idWord = 16'h0000;
        idWord[`ADC_ID_CODE_MSB:`ADC_ID_CODE_LSB] = DEVICE_CODE;
        idWord[`ADC_ID_COUNT_MSB:`ADC_ID_COUNT_LSB] = `ADC_CHANNEL_COUNT;
        idWord[7:0] = REVISION_BYTE;
    end

    ////////////////////////////////////////////////////////////////
    // Interface lock level, one cycle behind the core
    always_ff @(posedge clk) begin
        if (reset) begin
            locked_q <= `ADC_LOCK_RESET;
        end else begin
            locked_q <= coreEvents.ifaceLocked;
        end
    end

    // Checksum polynomial level
    always_ff @(posedge clk) begin
        if (reset) begin
            crcTypeAnsi_q <= `ADC_CRC_TYPE_RESET;
        end else begin
            crcTypeAnsi_q <= coreEvents.crcTypeAnsi;
        end
    end

    // Data word length code
    always_ff @(posedge clk) begin
        if (reset) begin
            wordLengthCode_q <= `ADC_WLEN_RESET;
        end else begin
            wordLengthCode_q <= coreEvents.wordLengthSel;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sticky event flags, cleared when the status word is read
    assign eventSet = {coreEvents.inputCrcErrPulse, coreEvents.regMapCrcChangedPulse, coreEvents.resyncPulse};
    assign eventClear = {3{statusReadAccept}};

    // Resync, map checksum change and input checksum error
    adc_flag_bank #(
        .WIDTH(3),
        .RESET_VALUE(3'h0)
    ) eventFlagBank (
        .clk(clk),
        .reset(reset),
        .setFlag(eventSet),
        .clearFlag(eventClear),
        .flagsD(),
        .flagsQ(eventFlags_q)
    );

    // New data per channel, cleared when the channel data is taken
    adc_flag_bank #(
        .WIDTH(6),
        .RESET_VALUE(6'h00)
    ) dataFlagBank (
        .clk(clk),
        .reset(reset),
        .setFlag(coreEvents.newDataPulse),
        .clearFlag(coreEvents.dataTakenPulse),
        .flagsD(),
        .flagsQ(dataFlags_q)
    );

    // Reset-occurred flag, set by reset, cleared by the core
    adc_flag_bank #(
        .WIDTH(1),
        .RESET_VALUE(`ADC_RESET_FLAG_RESET)
    ) resetFlagBank (
        .clk(clk),
        .reset(reset),
        .setFlag(1'b0),
        .clearFlag(coreEvents.resetFlagClear),
        .flagsD(),
        .flagsQ(resetFlag_q)
    );

    ////////////////////////////////////////////////////////////////
    // Assemble the status word
    always_comb begin
        status_d.locked = locked_q;
        status_d.resyncOccurred = eventFlags_q[0];
        status_d.regMapChanged = eventFlags_q[1];
        status_d.inputCrcError = eventFlags_q[2];
        status_d.crcTypeAnsi = crcTypeAnsi_q;
        status_d.resetOccurred = resetFlag_q[0];
        status_d.wordLengthCode = wordLengthCode_q;
        status_d.reserved = 2'h0;
        status_d.newData = dataFlags_q;
    end

    // Registered status copy for the frame logic
    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= `ADC_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interrupt sources and write-one-to-clear
    always_comb begin
        irqSet = '0;
        irqSet[`ADC_IRQ_RESYNC] = coreEvents.resyncPulse;
        irqSet[`ADC_IRQ_REGMAP] = coreEvents.regMapCrcChangedPulse;
        irqSet[`ADC_IRQ_CRCERR] = coreEvents.inputCrcErrPulse;
        irqSet[`ADC_IRQ_DATA_LSB +: 6] = coreEvents.newDataPulse;
    end

    // Write-one-to-clear from the enabled low lanes
    assign irqClear = irqStatusWriteAccept ? writeLow[`ADC_IRQ_WIDTH-1:0] : '0;

    // Interrupt status bits
    adc_flag_bank #(
        .WIDTH(`ADC_IRQ_WIDTH),
        .RESET_VALUE(`ADC_IRQ_WIDTH'(0))
    ) irqFlagBank (
        .clk(clk),
        .reset(reset),
        .setFlag(irqSet),
        .clearFlag(irqClear),
        .flagsD(irqStatus_d),
        .flagsQ(irqStatus_q)
    );

    // Interrupt mask, byte-lane aware
    always_ff @(posedge clk) begin
        if (reset) begin
            irqMask_q <= `ADC_IRQ_MASK_RESET;
        end else if (irqMaskWriteAccept) begin
            irqMask_q <= lane_merge(irqMask_q, writeLow[`ADC_IRQ_WIDTH-1:0], laneMask[`ADC_IRQ_WIDTH-1:0]);
        end
    end

    // Level interrupt from next status and mask
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irqStatus_d & irqMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data mux; writes to identity and status fall through
    always_comb begin
        readdata_d = 32'h0000_0000;
        if (read) begin
            unique case (regIndex)
                `ADC_IDX_ID: readdata_d[15:0] = idWord;
                `ADC_IDX_STATUS: readdata_d[15:0] = status_d;
                `ADC_IDX_IRQ_STATUS: readdata_d[`ADC_IRQ_WIDTH-1:0] = irqStatus_q;
                `ADC_IDX_IRQ_MASK: readdata_d[`ADC_IRQ_WIDTH-1:0] = irqMask_q;
                default: readdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured during the wait cycle, held otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            readdata_q <= 32'h0000_0000;
        end else if (readCapture) begin
            readdata_q <= readdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;
    assign statusOut = status_q;
    assign irq = irq_q;

endmodule

`default_nettype wire

// >>> adc_regs_asserts.sv
// Checker of the identification and status register block
`timescale 1ns/1ps
`default_nettype none
module adc_regs_asserts
    import adc_pkg::*;
#(
    parameter logic [3:0] DEVICE_CODE = 4'h5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire adc_core_events_type coreEvents,
    input wire adc_status_type statusOut,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Completing reads of the two registers
    wire logic idRd = read && !waitrequest && address[7:2] == 6'h00;
    wire logic stRd = read && !waitrequest && address[7:2] == 6'h01;
    ////////////////////////////////////////////////////////////////
    id_code_a: assert property (idRd |-> readdata[15:12] == DEVICE_CODE) else $error("Device code wrong");
    chan_count_a: assert property (idRd |-> readdata[11:8] == 4'h6) else $error("Channel count wrong");
    reset_value_a: assert property ($past(reset) |-> statusOut == 16'h0500) else $error("Status reset wrong");
    reset_flag_a: assert property (coreEvents.resetFlagClear |-> ##2 !statusOut.resetOccurred)
        else $error("Reset flag not cleared");
    lock_level_a: assert property (stRd |-> readdata[15] == $past(coreEvents.ifaceLocked, 2))
        else $error("Lock bit wrong");
    resync_set_a: assert property (coreEvents.resyncPulse |-> ##[1:2] statusOut.resyncOccurred)
        else $error("Resync flag not set");
    regmap_set_a: assert property (coreEvents.regMapCrcChangedPulse |-> ##[1:2] statusOut.regMapChanged)
        else $error("Map change flag not set");
    crc_err_a: assert property (coreEvents.inputCrcErrPulse |-> ##[1:2] statusOut.inputCrcError)
        else $error("Input error flag not set");
    crc_type_a: assert property (stRd |-> readdata[11] == $past(coreEvents.crcTypeAnsi, 2))
        else $error("Polynomial bit wrong");
    word_len_a: assert property (stRd |-> readdata[9:8] == $past(coreEvents.wordLengthSel, 2))
        else $error("Word length wrong");
    new_data_a: assert property (coreEvents.newDataPulse[0] |-> ##[1:2] statusOut.newData[0])
        else $error("New data flag not set");
    // Main scenarios reached
    cover property (stRd);
    cover property ($rose(irq));
    cover property (coreEvents.resyncPulse);
endmodule
bind adc_id_status_regs adc_regs_asserts #(.DEVICE_CODE(DEVICE_CODE)) adc_regs_asserts_i (.clk, .reset, .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .coreEvents, .statusOut, .irq);
`default_nettype wire

// >>> adc_host_model.sv
// Host controller model speaking Avalon-MM to the register block
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    input wire logic clk,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    // Idle bus at time zero
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
    end
    // One transfer, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~d; // Stale data not left on the bus
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> adc_id_status_registers_tb_top.sv
// Self-checking testbench of the identification and status register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errCount++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module adc_id_status_registers_tb_top
    import adc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address;
    logic read, write, waitrequest, irq;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    adc_core_events_type ev = '{wordLengthSel: 2'h1, default: 1'b0};
    adc_status_type statusOut;
    int errCount = 0;
    int checked = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    adc_id_status_regs adc_id_status_regs_i (.clk, .reset, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .coreEvents(ev), .statusOut, .irq);
    adc_host_model adc_host_model_i (.clk, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest);
    ////////////////////////////////////////////////////////////////
    // Bus and event helpers
    task automatic rd(input logic [7:0] a); adc_host_model_i.xfer(1'b0, a, 32'h0, 4'hf, q); endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); adc_host_model_i.xfer(1'b1, a, d, 4'hf, q); endtask
    task automatic pulse(input adc_core_events_type m);
        ev <= ev | m;
        @(posedge clk);
        ev <= ev & ~m;
        @(posedge clk);
    endtask
    // Reset value, then reset flag cleared
    task automatic testReset();
        adc_core_events_type m = '0;
        rd(8'h04);
        `CHK("status reset", 32'h0500, q)
        `CHK("status copy", 16'h0500, statusOut)
        m.resetFlagClear = 1'b1;
        pulse(m);
        rd(8'h04);
        `CHK("reset flag", 32'h0100, q)
        `CHK("status copy clear", 16'h0100, statusOut)
    endtask
    // Identity fields and ignored writes; low byte left unchecked
    task automatic testId();
        rd(8'h00);
        `CHK("id code", 8'h56, q[15:8])
        wr(8'h00, 32'hffff);
        wr(8'h04, 32'hffff);
        rd(8'h00);
        `CHK("id written", 8'h56, q[15:8])
        rd(8'h04);
        `CHK("status written", 32'h0100, q)
    endtask
    // Every word length with lock and polynomial levels
    task automatic testLevels();
        for (int w = 0; w < 4; w++) begin
            ev.wordLengthSel <= w[1:0];
            ev.ifaceLocked <= w[0];
            ev.crcTypeAnsi <= w[1];
            repeat (2) @(posedge clk);
            rd(8'h04);
            `CHK("levels", {16'h0, w[0], 3'h0, w[1], 1'b0, w[1:0], 8'h00}, q)
        end
        ev.wordLengthSel <= 2'h1;
        ev.ifaceLocked <= 1'b0;
        ev.crcTypeAnsi <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Sticky flags set by events, cleared by a read
    task automatic testSticky();
        adc_core_events_type m;
        logic [31:0] bitv[3] = '{32'h4000, 32'h2000, 32'h1000};
        for (int i = 0; i < 3; i++) begin
            m = '0;
            m.resyncPulse = (i == 0);
            m.regMapCrcChangedPulse = (i == 1);
            m.inputCrcErrPulse = (i == 2);
            pulse(m);
            rd(8'h04);
            `CHK("sticky set", 32'h0100 | bitv[i], q)
            rd(8'h04);
            `CHK("sticky clear", 32'h0100, q)
        end
    endtask
    // New data flag of each channel set and taken
    task automatic testData();
        adc_core_events_type m;
        for (int ch = 0; ch < 6; ch++) begin
            m = '0;
            m.newDataPulse[ch] = 1'b1;
            pulse(m);
            rd(8'h04);
            `CHK("new data", 32'h0100 | (32'h1 << ch), q)
            m = '0;
            m.dataTakenPulse[ch] = 1'b1;
            pulse(m);
            rd(8'h04);
            `CHK("data taken", 32'h0100, q)
        end
    endtask
    // Interrupt raised, cleared, masked; unmapped place
    task automatic testIrq();
        adc_core_events_type m = '0;
        wr(8'h08, 32'h1ff);
        wr(8'h0c, 32'h001);
        adc_host_model_i.xfer(1'b1, 8'h0c, 32'h1fe, 4'h2, q);
        rd(8'h0c);
        `CHK("mask lanes", 32'h101, q)
        m.resyncPulse = 1'b1;
        pulse(m);
        rd(8'h08);
        `CHK("irq status", 32'h001, q)
        `CHK("irq raised", 1'b1, irq)
        wr(8'h08, 32'h001);
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        wr(8'h0c, 32'h0);
        pulse(m);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        wr(8'h20, 32'hffff);
        rd(8'h20);
        `CHK("unmapped", 32'h0, q)
    endtask
    ////////////////////////////////////////////////////////////////
    // Closing report
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            errCount++;
            giveVerdict();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        testReset();
        testId();
        testLevels();
        testSticky();
        testData();
        testIrq();
        giveVerdict();
    end
endmodule
`default_nettype wire
